// File: verilog/sps_pkg.sv
// constants and helpers shared by the flash sequencer ends
// Behaviour
// - flash writes last 3.7 to 4.5 ms
// - boot size follows two fuse bits
// - readable-while-write region is 0x000 to 0xBFF
// - halt-on-write region is 0xC00 to 0xFFF
// - program counter is twelve bits wide
// - page holds 32 words, counter bits 4:0
// - page index from pointer bits 12:6
// - buffer word from pointer bits 5:1
// - pointer bits 15:13 always ignored
// - pointer bit 0 zero; selects load byte
// - only halt region fetchable during readable-region erase/write
// - poll enable bit low before new command
// - wait eeprom write idle before control write
// - mask interrupts around timed sequence, restore
// - busy region not fetched until re-enabled
// - page update: erase, reenable, loads, write, reenable
// - low byte first register, pointer plus two
// - re-enable after every erase and write
// - buffer load is control 01 then store
// - page write is control 05 then store
// - busy flag held until re-enable written
// - temp buffer erased by write, re-enable, reset
package sps_pkg;
	localparam int          CLK_PERIOD_NS      = 10;
	localparam int          FLASH_WRITE_MIN_NS = 3_700_000;
	localparam int          FLASH_WRITE_MAX_NS = 4_500_000;
	localparam int          WRITE_MIN_CYC      =
		(FLASH_WRITE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          WRITE_MAX_CYC      =
		FLASH_WRITE_MAX_NS / CLK_PERIOD_NS;
	localparam int          TIMER_W            = 20;
	localparam int          PC_W               = 12;
	localparam int          COUNTER_TOP_BIT    = 11;
	localparam int          PAGE_OFFSET_TOP_BIT = 4;
	localparam int          POINTER_TOP_BIT    = 12;
	localparam int          POINTER_OFFSET_TOP_BIT = 5;
	localparam int          PAGE_WORDS         = 32;
	localparam int          RWW_PAGES          = 96;
	localparam logic [11:0] RWW_LAST           = 12'hBFF;
	localparam logic [11:0] HALT_ON_WRITE_REGION_FIRST         = 12'hC00;
	localparam logic [11:0] BOOT_START_128     = 12'hF80;
	localparam logic [11:0] BOOT_START_256     = 12'hF00;
	localparam logic [11:0] BOOT_START_512     = 12'hE00;
	localparam logic [11:0] BOOT_START_1024    = 12'hC00;
	localparam logic [15:0] FLASH_ERASED       = 16'hFFFF;
	localparam logic [7:0]  BYTE_BLOCKED       = 8'hFF;
	localparam logic [2:0]  STORE_WINDOW_CYC   = 3'h4;
	// control register bit positions
	localparam int          SPM_EN_BIT         = 0;
	localparam int          PAGE_ERASE_BIT     = 1;
	localparam int          PAGE_WRITE_BIT     = 2;
	localparam int          LOCK_SET_BIT       = 3;
	localparam int          REENABLE_BIT       = 4;
	localparam int          BUSY_BIT           = 6;
	localparam logic [7:0]  CMD_BUFFER_LOAD    = 8'h01;
	localparam logic [7:0]  CMD_PAGE_ERASE     = 8'h03;
	localparam logic [7:0]  CMD_PAGE_WRITE     = 8'h05;
	localparam logic [7:0]  CMD_REENABLE       = 8'h11;
	// host sequence steps
	localparam logic [5:0]  STEP_ERASE         = 6'h00;
	localparam logic [5:0]  STEP_REEN1         = 6'h01;
	localparam logic [5:0]  STEP_LOAD0         = 6'h02;
	localparam logic [5:0]  STEP_WRITE         = 6'h22;
	localparam logic [5:0]  STEP_REEN2         = 6'h23;
	// host register offsets on the register bus
	localparam logic [7:0]  REG_CMD            = 8'h00;
	localparam logic [7:0]  REG_ADDR           = 8'h04;
	localparam logic [7:0]  REG_DATA           = 8'h08;
	localparam logic [7:0]  REG_STATUS         = 8'h0C;
	localparam logic [1:0]  RESP_OKAY          = 2'h0;

	function automatic logic [11:0] sps_boot_start(input logic [1:0] f);
		case (f)
			2'h3:    return BOOT_START_128;
			2'h2:    return BOOT_START_256;
			2'h1:    return BOOT_START_512;
			default: return BOOT_START_1024;
		endcase
	endfunction : sps_boot_start
endpackage : sps_pkg

// File: verilog/sps_link_if.sv
// link between the boot-loader controller and the flash sequencer
`timescale 1ns/1ps
interface sps_link_if;
	logic        ctrl_wr;
	logic [7:0]  ctrl_wdata;
	logic [7:0]  ctrl_rdata;
	logic        store;
	logic        load;
	logic [15:0] pointer;
	logic [15:0] store_data;
	logic [7:0]  load_data;
	logic        load_valid;
	logic        eeprom_write_active;
	logic [11:0] fetch_addr;
	logic        fetch_blocked;

	modport dev (
		input  ctrl_wr, ctrl_wdata, store, load, pointer, store_data,
		input  eeprom_write_active, fetch_addr,
		output ctrl_rdata, load_data, load_valid, fetch_blocked
	);
	modport host (
		output ctrl_wr, ctrl_wdata, store, load, pointer, store_data,
		output eeprom_write_active, fetch_addr,
		input  ctrl_rdata, load_data, load_valid, fetch_blocked
	);
endinterface : sps_link_if

// File: verilog/sps_write_timer.sv
// timer for one flash write operation
`timescale 1ns/1ps
module sps_write_timer
	import sps_pkg::*;
#(
	parameter int CYCLES = WRITE_MIN_CYC
) (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	// control
	input  wire logic i_start,
	output logic      o_busy,
	output logic      o_done
);
	logic [TIMER_W-1:0] count;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			count  <= '0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end else if (i_start && !o_busy) begin
			count  <= TIMER_W'(CYCLES - 1);
			o_busy <= 1'b1;
			o_done <= 1'b0;
		end else if (o_busy && count == '0) begin
			o_busy <= 1'b0;
			o_done <= 1'b1;
		end else begin
			count  <= o_busy ? count - 1'b1 : count;
			o_done <= 1'b0;
		end
	end
endmodule : sps_write_timer

// File: verilog/sps_flash_dev.sv
// flash self-programming sequencer, device end
`timescale 1ns/1ps
module sps_flash_dev
	import sps_pkg::*;
#(
	// least write time rounds up; shorten for simulation
	parameter int WRITE_CYCLES = WRITE_MIN_CYC
) (
	// clock and reset
	input  wire logic  i_mclk,
	input  wire logic  i_rst_n,
	// link to the controller
	sps_link_if.dev    link,
	// boot size fuses
	input  wire logic [1:0] i_boot_size,
	// status
	output logic [11:0] o_boot_start,
	output logic [11:0] o_app_end,
	output logic        o_write_active,
	output logic        o_rww_busy
);
	logic [15:0] flash [2**PC_W];
	logic [15:0] page_buf [PAGE_WORDS];
	logic        spm_en;
	logic [3:0]  cmd;
	logic [2:0]  win;
	logic        rww_busy;
	logic        halt_all;
	logic        flash_op;
	logic        t_busy;
	logic        t_done;
	logic        store_go;
	logic        go_erase;
	logic        go_write;
	logic        go_lock;
	logic        go_reen;
	logic        go_load;
	logic        timed_go;
	logic        accept_wr;
	logic [6:0]  page_idx;
	logic [4:0]  word_idx;
	logic [11:0] load_word;
	logic        page_in_rww;
	logic        fetch_in_rww;

	// pointer bits 15:13 never looked at
	assign page_idx  = link.pointer[POINTER_TOP_BIT:6];
	assign word_idx  = link.pointer[POINTER_OFFSET_TOP_BIT:1];
	assign load_word = link.pointer[POINTER_TOP_BIT:1];
	assign page_in_rww  = page_idx < 7'(RWW_PAGES);
	assign fetch_in_rww = link.fetch_addr <= RWW_LAST;

	// eeprom writes lock the control register out
	assign accept_wr = link.ctrl_wr && !link.eeprom_write_active && !spm_en;
	assign store_go  = link.store && spm_en && win != 3'h0 && !t_busy;
	assign go_erase  = store_go && cmd == CMD_PAGE_ERASE[4:1];
	assign go_write  = store_go && cmd == CMD_PAGE_WRITE[4:1];
	assign go_lock   = store_go && cmd[LOCK_SET_BIT-1];
	assign go_reen   = store_go && cmd == CMD_REENABLE[4:1];
	assign go_load   = store_go && cmd == 4'h0;
	assign timed_go  = go_erase || go_write || go_lock;

	sps_write_timer #(
		.CYCLES  (WRITE_CYCLES)
	) u_timer (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_start (timed_go),
		.o_busy  (t_busy),
		.o_done  (t_done)
	);

	// control register and the four-cycle store window
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			spm_en <= 1'b0;
			cmd    <= 4'h0;
			win    <= 3'h0;
		end else if (t_done) begin
			spm_en <= 1'b0;
			cmd    <= 4'h0;
			win    <= 3'h0;
		end else if (accept_wr) begin
			spm_en <= link.ctrl_wdata[SPM_EN_BIT];
			cmd    <= link.ctrl_wdata[REENABLE_BIT:PAGE_ERASE_BIT];
			win    <= STORE_WINDOW_CYC;
		end else if (store_go) begin
			// timed operations keep the enable bit until done
			spm_en <= timed_go;
			cmd    <= timed_go ? cmd : 4'h0;
			win    <= 3'h0;
		end else if (win == 3'h1) begin
			spm_en <= 1'b0;
			cmd    <= 4'h0;
			win    <= 3'h0;
		end else if (win != 3'h0) begin
			win <= win - 3'h1;
		end
	end

	// region-busy flag
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			rww_busy <= 1'b0;
		end else if ((go_erase || go_write) && page_in_rww) begin
			rww_busy <= 1'b1;
		end else if (go_reen) begin
			rww_busy <= 1'b0;
		end
	end

	// what the running write shuts out of the fetch path
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			halt_all <= 1'b0;
			flash_op <= 1'b0;
		end else if (timed_go) begin
			halt_all <= (go_erase || go_write) && !page_in_rww;
			flash_op <= go_erase || go_write;
		end else if (t_done) begin
			halt_all <= 1'b0;
			flash_op <= 1'b0;
		end
	end

	// temporary page buffer
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || go_write || go_reen) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				page_buf[i] <= FLASH_ERASED;
			end
		end else if (go_load) begin
			page_buf[word_idx] <= link.store_data;
		end
	end

	// flash array, committed when the timed operation starts
	always_ff @(posedge i_mclk) begin
		if (go_erase || go_write) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				flash[{page_idx, 5'(i)}] <=
					go_erase ? FLASH_ERASED : page_buf[i];
			end
		end
	end

	// program memory load, one cycle after the request
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			link.load_valid <= 1'b0;
			link.load_data  <= 8'h00;
		end else begin
			link.load_valid <= link.load;
			if (rww_busy && load_word <= RWW_LAST) begin
				link.load_data <= BYTE_BLOCKED;
			end else begin
				link.load_data <= link.pointer[0] ?
					flash[load_word][15:8] : flash[load_word][7:0];
			end
		end
	end

	// instruction fetch gate
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			link.fetch_blocked <= 1'b0;
		end else begin
			link.fetch_blocked <= halt_all
				|| (flash_op && fetch_in_rww)
				|| (rww_busy && fetch_in_rww);
		end
	end

	// fuse decode and status outputs
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_boot_start   <= BOOT_START_1024;
			o_app_end      <= RWW_LAST;
			o_write_active <= 1'b0;
			o_rww_busy     <= 1'b0;
		end else begin
			o_boot_start   <= sps_boot_start(i_boot_size);
			o_app_end      <= sps_boot_start(i_boot_size) - 12'h001;
			o_write_active <= t_busy;
			o_rww_busy     <= rww_busy;
		end
	end

	// control register as the controller reads it
	assign link.ctrl_rdata = {1'b0, rww_busy, 1'b0, cmd, spm_en};
endmodule : sps_flash_dev

// File: verilog/sps_boot_host.sv
// boot-loader controller end, driven over a register bus
`timescale 1ns/1ps
module sps_boot_host
	import sps_pkg::*;
(
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	// register bus
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	output logic [1:0]       o_bresp,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	input  wire logic [7:0]  i_araddr,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	// system side
	input  wire logic        i_eeprom_busy,
	input  wire logic        i_irq_enable,
	input  wire logic [11:0] i_fetch_addr,
	output logic             o_irq_enable,
	output logic             o_fetch_blocked,
	// link to the sequencer
	sps_link_if.host         link
);
	typedef enum logic [2:0] {
		SPS_IDLE, SPS_POLL, SPS_EEWAIT, SPS_CTRL, SPS_STORE, SPS_NEXT,
		SPS_CHECK, SPS_LWAIT
	} sps_state_e;

	sps_state_e  state;
	logic [15:0] wbuf [PAGE_WORDS];
	logic [4:0]  widx;
	logic [15:0] addr;
	logic [5:0]  step;
	logic [7:0]  rd_byte;
	logic        busy;
	logic        done;
	logic        saved_ie;
	logic        go_page;
	logic        go_read;
	logic        aw_got;
	logic        w_got;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [15:0] page_base;
	logic [4:0]  load_idx;

	// upper and word bits forced low for erase and write stores
	assign page_base = {3'h0, addr[POINTER_TOP_BIT:6], 6'h00};
	assign load_idx  = 5'(step - STEP_LOAD0);
	assign busy      = state != SPS_IDLE;
	assign o_bresp   = RESP_OKAY;
	assign o_rresp   = RESP_OKAY;

	// write channels, taken in either order
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_awready <= 1'b1;
			o_wready  <= 1'b1;
			aw_got    <= 1'b0;
			w_got     <= 1'b0;
			aw_addr   <= 8'h00;
			w_data    <= 32'h0000_0000;
			o_bvalid  <= 1'b0;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_got    <= 1'b1;
				aw_addr   <= i_awaddr;
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_got    <= 1'b1;
				w_data   <= i_wdata;
				o_wready <= 1'b0;
			end
			if (aw_got && w_got) begin
				aw_got   <= 1'b0;
				w_got    <= 1'b0;
				o_bvalid <= 1'b1;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid  <= 1'b0;
				o_awready <= 1'b1;
				o_wready  <= 1'b1;
			end
		end
	end

	// register effects of a completed write
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			addr    <= 16'h0000;
			widx    <= 5'h00;
			go_page <= 1'b0;
			go_read <= 1'b0;
		end else begin
			go_page <= 1'b0;
			go_read <= 1'b0;
			if (aw_got && w_got) begin
				case (aw_addr)
					REG_CMD: begin
						// commands while busy are dropped
						go_page <= w_data[0] && !busy;
						go_read <= w_data[1] && !busy;
					end
					REG_ADDR: begin
						addr <= w_data[15:0];
						widx <= 5'h00;
					end
					REG_DATA: begin
						wbuf[widx] <= w_data[15:0];
						widx       <= widx + 5'h01;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// read channel
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0000_0000;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b1;
			case (i_araddr)
				REG_ADDR:   o_rdata <= {16'h0000, addr};
				REG_STATUS: o_rdata <= {link.ctrl_rdata, 7'h00,
					!o_irq_enable, rd_byte, 6'h00, done, busy};
				default:    o_rdata <= 32'h0000_0000;
			endcase
		end else if (o_rvalid && i_rready) begin
			o_rvalid  <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// system-side registers
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			link.eeprom_write_active <= 1'b0;
			link.fetch_addr          <= 12'h000;
			o_fetch_blocked          <= 1'b0;
		end else begin
			link.eeprom_write_active <= i_eeprom_busy;
			link.fetch_addr          <= i_fetch_addr;
			o_fetch_blocked          <= link.fetch_blocked;
		end
	end

	// programming sequence
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state           <= SPS_IDLE;
			step            <= STEP_ERASE;
			done            <= 1'b0;
			rd_byte         <= 8'h00;
			saved_ie        <= 1'b0;
			o_irq_enable    <= 1'b0;
			link.ctrl_wr    <= 1'b0;
			link.ctrl_wdata <= 8'h00;
			link.store      <= 1'b0;
			link.load       <= 1'b0;
			link.pointer    <= 16'h0000;
			link.store_data <= 16'h0000;
		end else begin
			case (state)
				SPS_IDLE: begin
					o_irq_enable <= i_irq_enable;
					step         <= STEP_ERASE;
					if (go_page) begin
						done  <= 1'b0;
						state <= SPS_POLL;
					end else if (go_read) begin
						done         <= 1'b0;
						link.pointer <= addr;
						link.load    <= 1'b1;
						state        <= SPS_LWAIT;
					end
				end
				SPS_POLL: begin
					if (!link.ctrl_rdata[SPM_EN_BIT]) begin
						saved_ie     <= o_irq_enable;
						o_irq_enable <= 1'b0;
						state        <= SPS_EEWAIT;
					end
				end
				SPS_EEWAIT: begin
					if (!link.eeprom_write_active) begin
						state <= SPS_CTRL;
					end
				end
				SPS_CTRL: begin
					link.ctrl_wr <= 1'b1;
					if (step == STEP_ERASE) begin
						link.ctrl_wdata <= CMD_PAGE_ERASE;
						link.pointer    <= page_base;
					end else if (step == STEP_WRITE) begin
						link.ctrl_wdata <= CMD_PAGE_WRITE;
						link.pointer    <= page_base;
					end else if (step >= STEP_LOAD0 && step < STEP_WRITE) begin
						link.ctrl_wdata <= CMD_BUFFER_LOAD;
						link.pointer    <= page_base | {10'h000, load_idx, 1'b0};
						link.store_data <= wbuf[load_idx];
					end else begin
						link.ctrl_wdata <= CMD_REENABLE;
					end
					state <= SPS_STORE;
				end
				SPS_STORE: begin
					// store lands one cycle after the control write
					link.ctrl_wr <= 1'b0;
					link.store   <= 1'b1;
					state        <= SPS_NEXT;
				end
				SPS_NEXT: begin
					link.store   <= 1'b0;
					o_irq_enable <= saved_ie;
					if (step == STEP_REEN2) begin
						state <= SPS_CHECK;
					end else begin
						step  <= step + 6'h01;
						state <= SPS_POLL;
					end
				end
				SPS_CHECK: begin
					if (!link.ctrl_rdata[SPM_EN_BIT]) begin
						if (link.ctrl_rdata[BUSY_BIT]) begin
							state <= SPS_POLL;
						end else begin
							done  <= 1'b1;
							state <= SPS_IDLE;
						end
					end
				end
				SPS_LWAIT: begin
					link.load <= 1'b0;
					if (link.load_valid) begin
						rd_byte <= link.load_data;
						done    <= 1'b1;
						state   <= SPS_IDLE;
					end
				end
				default: state <= SPS_IDLE;
			endcase
		end
	end
endmodule : sps_boot_host

// File: dv/sps_link_asserts.sv
// link-level checks between the boot-loader controller and the sequencer
`timescale 1ns/1ps
module sps_link_asserts
	import sps_pkg::*;
#(
	parameter int WRITE_CYCLES = 20
) (
	// clock and reset
	input wire logic        i_mclk,
	input wire logic        i_rst_n,
	// link signals
	input wire logic        ctrl_wr,
	input wire logic [7:0]  ctrl_wdata,
	input wire logic [7:0]  ctrl_rdata,
	input wire logic        store,
	input wire logic        load,
	input wire logic [15:0] pointer,
	input wire logic [15:0] store_data,
	input wire logic [7:0]  load_data,
	input wire logic        load_valid,
	input wire logic        eeprom_write_active,
	input wire logic [11:0] fetch_addr,
	input wire logic        fetch_blocked
);
	// clear edge allowed one cycle of slack for the registered flag
	localparam int HOLD   = WRITE_CYCLES;
	localparam int CLR_LO = WRITE_CYCLES + 1;
	localparam int CLR_HI = WRITE_CYCLES + 2;
	logic timed_go;
	logic untimed_go;
	logic busy;
	assign timed_go   = store && ctrl_rdata[0] &&
		(ctrl_rdata[3:1] == 3'h1 || ctrl_rdata[3:1] == 3'h2);
	assign untimed_go = store && ctrl_rdata[3:0] == 4'h1;
	assign busy       = ctrl_rdata[BUSY_BIT];
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	chk_timed_min: assert property (timed_go |-> ##HOLD ctrl_rdata[0])
		else $error("enable bit dropped before least write time");
	chk_timed_end: assert property (
		timed_go |-> ##[CLR_LO:CLR_HI] !ctrl_rdata[0])
		else $error("enable bit not cleared after timed write");
	chk_untimed_clr: assert property (
		untimed_go |=> !ctrl_rdata[0])
		else $error("enable bit held after untimed store");
	chk_write_ptr: assert property (
		timed_go |-> pointer[15:13] == 3'h0 && pointer[5:0] == 6'h00)
		else $error("page pointer carries stray bits");
	chk_busy_set: assert property (
		timed_go && pointer[12:6] < 7'h60 |=> busy)
		else $error("busy flag not set by readable region write");
	chk_busy_halt: assert property (
		timed_go && pointer[12:6] >= 7'h60 && !busy |=> !busy)
		else $error("busy flag set by halt region write");
	chk_busy_hold: assert property (busy && !untimed_go |=> busy)
		else $error("busy flag dropped without re-enable");
	chk_reen_clr: assert property (
		untimed_go && ctrl_rdata[4] |=> !busy)
		else $error("busy flag kept after re-enable");
	chk_fetch_rww: assert property (
		busy && fetch_addr <= 12'hBFF |=> fetch_blocked)
		else $error("readable region fetched while busy");
	chk_fetch_idle: assert property (
		(!busy && !ctrl_rdata[0]) [*2] |=> !fetch_blocked)
		else $error("fetch blocked while idle");
	chk_load_resp: assert property (load_valid |-> $past(load))
		else $error("load answer without load request");
endmodule : sps_link_asserts

// File: dv/tb.sv
// self-checking bench for the controller and sequencer pair
`timescale 1ns/1ps
module tb
	import sps_pkg::*;
;
	localparam int WR_CYC = 20;
	typedef struct {logic u; logic [31:0] m; logic [31:0] e;} sps_note_s;
	logic        i_mclk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        eeprom_busy, irq_en;
	logic        o_write_active, o_rww_busy;
	int          blk_cnt = 0;
	int          act_cnt = 0;
	int          rwb_cnt = 0;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic        o_irq_enable, o_fetch_blocked;
	logic [1:0]  boot_size;
	logic [7:0]  awaddr, araddr;
	logic [11:0] fetch_addr, o_boot_start, o_app_end;
	logic [31:0] wdata, rd, o_rdata;
	logic [15:0] lfsr = 16'hE32E;
	logic [15:0] words [32];
	logic [11:0] starts [4] = '{12'hC00, 12'hE00, 12'hF00, 12'hF80};
	sps_note_s   exp_q [$];
	sps_note_s   note;
	int          num_errors = 0;
	int          num_checks = 0;

	sps_link_if link_inst ();
	sps_flash_dev #(.WRITE_CYCLES(WR_CYC)) sps_flash_dev_inst (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(link_inst),
		.i_boot_size(boot_size), .o_boot_start(o_boot_start),
		.o_app_end(o_app_end), .o_write_active(o_write_active),
		.o_rww_busy(o_rww_busy));
	sps_boot_host sps_boot_host_inst (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_awvalid(awvalid), .o_awready(o_awready), .i_awaddr(awaddr),
		.i_wvalid(wvalid), .o_wready(o_wready), .i_wdata(wdata),
		.i_wstrb(4'hF), .o_bvalid(o_bvalid), .i_bready(bready),
		.o_bresp(), .i_arvalid(arvalid), .o_arready(o_arready),
		.i_araddr(araddr), .o_rvalid(o_rvalid), .i_rready(rready),
		.o_rdata(o_rdata), .o_rresp(), .i_eeprom_busy(eeprom_busy),
		.i_irq_enable(irq_en), .i_fetch_addr(fetch_addr),
		.o_irq_enable(o_irq_enable), .o_fetch_blocked(o_fetch_blocked),
		.link(link_inst));
	sps_link_asserts #(.WRITE_CYCLES(WR_CYC)) sps_link_asserts_inst (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .ctrl_wr(link_inst.ctrl_wr),
		.ctrl_wdata(link_inst.ctrl_wdata),
		.ctrl_rdata(link_inst.ctrl_rdata), .store(link_inst.store),
		.load(link_inst.load), .pointer(link_inst.pointer),
		.store_data(link_inst.store_data),
		.load_data(link_inst.load_data),
		.load_valid(link_inst.load_valid),
		.eeprom_write_active(link_inst.eeprom_write_active),
		.fetch_addr(link_inst.fetch_addr),
		.fetch_blocked(link_inst.fetch_blocked));

	initial begin
		forever #5 i_mclk = ~i_mclk;
	end

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
	endfunction : lfsr_next

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		bready  <= 1'b1;
		do begin
			@(posedge i_mclk);
			if (awvalid && o_awready) awvalid <= 1'b0;
			if (wvalid && o_wready) wvalid <= 1'b0;
		end while (o_bvalid !== 1'b1);
		bready <= 1'b0;
	endtask : axi_wr

	// u low: polling read, answer not compared
	task automatic axi_rd(input logic [7:0] a, input logic u,
		input logic [31:0] m, input logic [31:0] e);
		exp_q.push_back('{u, m, e});
		@(posedge i_mclk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		do begin
			@(posedge i_mclk);
			if (arvalid && o_arready) arvalid <= 1'b0;
		end while (o_rvalid !== 1'b1);
		rd = o_rdata;
		rready <= 1'b0;
	endtask : axi_rd

	task automatic wait_done();
		do begin
			axi_rd(REG_STATUS, 1'b0, 32'h0, 32'h0);
		end while (rd[1:0] !== 2'h2);
	endtask : wait_done

	always @(posedge i_mclk) begin
		if (o_rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			if (note.u) check(o_rdata & note.m, note.e);
		end
		if (o_fetch_blocked === 1'b1) blk_cnt++;
		if (o_write_active === 1'b1) act_cnt++;
		if (o_rww_busy === 1'b1) rwb_cnt++;
	end

	// page update, then byte read-back of a few words of the page
	task automatic upd(input logic [6:0] pg, input logic [11:0] fa);
		int i;
		int w;
		int blk0;
		int act0;
		int rwb0;
		axi_wr(REG_ADDR, {16'h0, lfsr[2:0], pg, 6'h00});
		for (i = 0; i < 32; i++) begin
			lfsr = lfsr_next(lfsr);
			words[i] = lfsr;
			axi_wr(REG_DATA, {16'h0, lfsr});
		end
		eeprom_busy <= 1'b1;
		irq_en      <= pg[0];
		axi_wr(REG_CMD, 32'h1);
		repeat (40) @(posedge i_mclk);
		check({31'h0, link_inst.ctrl_rdata[0]}, 32'h0);
		check({31'h0, o_irq_enable}, 32'h0);
		fetch_addr  <= fa;
		eeprom_busy <= 1'b0;
		blk0 = blk_cnt;
		act0 = act_cnt;
		rwb0 = rwb_cnt;
		wait_done();
		check(32'(blk_cnt != blk0), 32'h1);
		check({31'h0, o_irq_enable}, {31'h0, pg[0]});
		// erase and write each keep the timer busy for WR_CYC edges
		check(act_cnt - act0, 2 * WR_CYC);
		check(32'(rwb_cnt != rwb0), 32'(pg < 7'h60));
		repeat (3) @(posedge i_mclk);
		check({31'h0, o_fetch_blocked}, 32'h0);
		axi_rd(REG_STATUS, 1'b1, 32'h40000000, 32'h0);
		for (i = 0; i < 4; i++) begin
			w = i * 10 + 1;
			axi_wr(REG_ADDR, {16'h0, 3'h5, pg, w[4:0], i[0]});
			axi_wr(REG_CMD, 32'h2);
			wait_done();
			axi_rd(REG_STATUS, 1'b1, 32'h0000FF00, {16'h0,
				(i[0] ? words[w][15:8] : words[w][7:0]), 8'h00});
		end
		axi_rd(REG_ADDR, 1'b1, 32'h0000FFFF, {16'h0, 3'h5, pg, 6'h3F});
	endtask : upd

	initial begin
		int i;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		eeprom_busy = 1'b0;
		irq_en = 1'b1;
		fetch_addr = 12'hC00;
		boot_size = 2'h0;
		repeat (10) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		for (i = 0; i < 4; i++) begin
			@(posedge i_mclk);
			boot_size <= i[1:0];
			repeat (3) @(posedge i_mclk);
			check({20'h0, o_boot_start}, {20'h0, starts[i]});
			check({20'h0, o_app_end}, {20'h0, starts[i] - 12'h1});
		end
		upd(7'h05, 12'h0A0);
		upd(7'h64, 12'hC80);
		axi_wr(8'h14, {16'h0, lfsr});
		axi_rd(8'h10, 1'b1, 32'hFFFFFFFF, 32'h0);
		give_verdict();
	end

	// both page updates need a few thousand cycles at most
	initial begin
		repeat (20000) @(posedge i_mclk);
		num_errors++;
		give_verdict();
	end
endmodule : tb
